// ---- design/adcof_pkg.sv ----
package adcof_pkg;

  // Word and field widths
  localparam int ADCOF_WORD_W     = 14;
  localparam int ADCOF_HALF_W     = 7;
  localparam int ADCOF_SMP_W      = 12;
  localparam int ADCOF_REG_W      = 11;
  localparam int ADCOF_ADDR_W     = 5;
  localparam int ADCOF_FRAME_W    = 16;
  localparam int ADCOF_FIFO_DEPTH = 16;
  localparam logic [4:0] ADCOF_FRAME_LAST = 5'h0F;

  // Register addresses on the serial port
  localparam logic [4:0] ADCOF_ADDR_TIMING   = 5'h04;
  localparam logic [4:0] ADCOF_ADDR_ORDER    = 5'h09;
  localparam logic [4:0] ADCOF_ADDR_PATFMT   = 5'h0A;
  localparam logic [4:0] ADCOF_ADDR_USER_LO  = 5'h0B;
  localparam logic [4:0] ADCOF_ADDR_GAIN     = 5'h0C;
  localparam logic [4:0] ADCOF_ADDR_LVDS     = 5'h0E;

  // Field positions
  localparam int ADCOF_POS_DATA_SHIFT = 10;
  localparam int ADCOF_POS_CAP_EDGE   = 9;
  localparam int ADCOF_POS_CLK_DELAY  = 8;
  localparam int ADCOF_POS_BYTE_ORDER = 10;
  localparam int ADCOF_POS_CODING     = 10;
  localparam int ADCOF_POS_PATTERN    = 5;
  localparam int ADCOF_POS_USER_LO    = 4;
  localparam int ADCOF_POS_USER_HI    = 0;
  localparam int ADCOF_POS_GAIN       = 8;
  localparam int ADCOF_POS_CURR       = 2;
  localparam int ADCOF_POS_DATA_DBL   = 0;
  localparam int ADCOF_POS_CLK_DBL    = 1;
  localparam int ADCOF_POS_DATA_TERM  = 7;
  localparam int ADCOF_POS_CLK_TERM   = 4;

  // Reset value and writable bits of each register
  localparam logic [10:0] ADCOF_REG_RST     = 11'h000;
  localparam logic [10:0] ADCOF_MASK_TIMING = 11'h700;
  localparam logic [10:0] ADCOF_MASK_ORDER  = 11'h400;
  localparam logic [10:0] ADCOF_MASK_PATFMT = 11'h4E0;
  localparam logic [10:0] ADCOF_MASK_USERLO = 11'h7F0;
  localparam logic [10:0] ADCOF_MASK_GAIN   = 11'h71F;
  localparam logic [10:0] ADCOF_MASK_LVDS   = 11'h3FF;

  // Fixed pattern words
  localparam logic [13:0] ADCOF_WORD_ZERO  = 14'h0000;
  localparam logic [13:0] ADCOF_WORD_ONES  = 14'h3FFF;
  localparam logic [13:0] ADCOF_WORD_TOG_A = 14'h2AAA;
  localparam logic [13:0] ADCOF_WORD_TOG_B = 14'h1555;
  localparam logic [13:0] ADCOF_RAMP_START = 14'h0000;

  typedef enum logic [2:0] {
    ADCOF_PAT_ADC    = 3'b000,
    ADCOF_PAT_ZERO   = 3'b001,
    ADCOF_PAT_ONES   = 3'b010,
    ADCOF_PAT_TOGGLE = 3'b011,
    ADCOF_PAT_RAMP   = 3'b100,
    ADCOF_PAT_USER   = 3'b101,
    ADCOF_PAT_RSV6   = 3'b110,
    ADCOF_PAT_RSV7   = 3'b111
  } adcof_pat_e;

  typedef enum logic [1:0] {
    ADCOF_SER_IDLE  = 2'b00,
    ADCOF_SER_SHIFT = 2'b01,
    ADCOF_SER_DONE  = 2'b10
  } adcof_ser_e;

  // Settings that the link side needs
  typedef struct packed {
    logic clk_delay;
    logic cap_edge;
    logic data_shift;
    logic byte_order;
  } adcof_link_cfg_s;

  localparam adcof_link_cfg_s ADCOF_LINK_CFG_RST = '0;

  // Binary to gray
  function automatic logic [4:0] adcof_gray(input logic [4:0] b);
    adcof_gray = b ^ (b >> 1);
  endfunction

  // Even bits of a word, bit 0 first
  function automatic logic [6:0] adcof_even(input logic [13:0] w);
    logic [6:0] r;
    r = '0;
    for (int i = 0; i < 7; i++) begin
      r[i] = w[2*i];
    end
    adcof_even = r;
  endfunction

  // Odd bits of a word, bit 1 first
  function automatic logic [6:0] adcof_odd(input logic [13:0] w);
    logic [6:0] r;
    r = '0;
    for (int i = 0; i < 7; i++) begin
      r[i] = w[2*i+1];
    end
    adcof_odd = r;
  endfunction

endpackage

// ---- design/adcof_top.sv ----
`timescale 1ns/1ps
// Summary of operation
// - D8 of reg 04 delays output clock
// - D9 of reg 04 picks capture edge
// - D10 of reg 04 delays data half cycle
// - Bit-wise order: even rising, odd falling
// - Byte-wise order: low rising, high falling
// - Pattern codes: samples, zeros, ones; 11x unused
// - Toggle pattern alternates 0x2AAA and 0x1555
// - Ramp pattern counts up by one
// - User pattern drives output word
// - D10 of reg 0A selects sample coding
// - Reg 0B D10-D4 give low seven bits
// - Reg 0C D4-D0 give upper five bits
// - Reg 0C D10-D8 set fine gain
// - Reg 0E D3-D2 select LVDS current
// - Reg 0E D0, D1 double data/clock current
// - Reg 0E termination codes for data, clock

// Dual-clock FIFO with gray-coded pointers
module adcof_fifo #(
  parameter int W = 14,
  parameter int D = 16
) (
  input  wire logic         wr_clk,
  input  wire logic         wr_rst,
  input  wire logic         wr_valid,
  input  wire logic [W-1:0] wr_data,
  output logic              wr_ready,
  input  wire logic         rd_clk,
  input  wire logic         rd_rst,
  output logic              rd_valid,
  output logic [W-1:0]      rd_data,
  input  wire logic         rd_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wbin_reg, wgray_reg, rbin_reg, rgray_reg;
  logic [AW:0]  rg_q1, rg_q2, wg_q1, wg_q2;
  logic         ready_reg, empty_reg;
  logic [AW:0]  wbin_next, wgray_next, rbin_next, rgray_next;
  wire          push = wr_valid & ready_reg;
  wire          pop  = ~empty_reg & rd_ready;
  // Pointer arithmetic
  assign wbin_next  = wbin_reg + {{AW{1'b0}}, push};
  assign wgray_next = wbin_next ^ (wbin_next >> 1);
  assign rbin_next  = rbin_reg + {{AW{1'b0}}, pop};
  assign rgray_next = rbin_next ^ (rbin_next >> 1);
  assign wr_ready   = ready_reg;
  assign rd_valid   = ~empty_reg;
  assign rd_data    = mem[rbin_reg[AW-1:0]];
  // Storage write
  always_ff @(posedge wr_clk) begin
    if (push) begin
      mem[wbin_reg[AW-1:0]] <= wr_data;
    end
  end
  // Write side pointer and ready flag, kept in a flop for the top port
  always_ff @(posedge wr_clk or posedge wr_rst) begin
    if (wr_rst) begin
      wbin_reg  <= '0;
      wgray_reg <= '0;
      rg_q1     <= '0;
      rg_q2     <= '0;
      ready_reg <= 1'b1;
    end else begin
      wbin_reg  <= wbin_next;
      wgray_reg <= wgray_next;
      rg_q1     <= rgray_reg;
      rg_q2     <= rg_q1;
      ready_reg <= wgray_next != {~rg_q2[AW:AW-1], rg_q2[AW-2:0]};
    end
  end
  // Read side pointer and empty flag
  always_ff @(posedge rd_clk or posedge rd_rst) begin
    if (rd_rst) begin
      rbin_reg  <= '0;
      rgray_reg <= '0;
      wg_q1     <= '0;
      wg_q2     <= '0;
      empty_reg <= 1'b1;
    end else begin
      rbin_reg  <= rbin_next;
      rgray_reg <= rgray_next;
      wg_q1     <= wgray_reg;
      wg_q2     <= wg_q1;
      empty_reg <= rgray_next == wg_q2;
    end
  end
endmodule

module adcof_top
  import adcof_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        link_clk,
  input  wire logic        ser_clk,
  input  wire logic        ser_data,
  input  wire logic        ser_en_n,
  input  wire logic [11:0] smp_data,
  input  wire logic        smp_valid,
  output logic             smp_ready,
  input  wire logic        link_hold,
  output logic [6:0]       dout_rise,
  output logic [6:0]       dout_fall,
  output logic             dout_valid,
  output logic             oclk_delay,
  output logic             oclk_falling,
  output logic [2:0]       fine_gain,
  output logic [1:0]       lvds_curr,
  output logic             data_curr_dbl,
  output logic             clk_curr_dbl,
  output logic [2:0]       data_term,
  output logic [2:0]       clk_term
);
  // Register file
  logic [10:0] timing_reg, order_reg, patfmt_reg;
  logic [10:0] userlo_reg, gain_reg, lvds_reg;
  // Serial port
  logic        sclk_q1, sclk_q2, sdat_q1, sdat_q2, sen_q1, sen_q2;
  logic        sclk_d_reg;
  adcof_ser_e  ser_state_reg, ser_state_next;
  logic [14:0] shift_reg;
  logic [4:0]  bit_cnt_reg;
  logic [15:0] frame_word;
  logic        sel_timing, sel_order, sel_patfmt;
  logic        sel_userlo, sel_gain, sel_lvds;
  // Serial edge and frame end
  wire ser_fall   = sclk_d_reg & ~sclk_q2;
  wire frame_done = (ser_state_reg == ADCOF_SER_SHIFT) & ~sen_q2 &
                    ser_fall & (bit_cnt_reg == ADCOF_FRAME_LAST);
  wire [4:0]  frame_addr = frame_word[15:11];
  wire [10:0] frame_data = frame_word[10:0];
  assign frame_word = {shift_reg, sdat_q2};
  // Pin synchronisers for the serial port
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {sclk_q1, sclk_q2, sclk_d_reg} <= 3'h0;
      {sdat_q1, sdat_q2}             <= 2'h0;
      {sen_q1, sen_q2}               <= 2'h3;
    end else begin
      {sclk_q1, sclk_q2, sclk_d_reg} <= {ser_clk, sclk_q1, sclk_q2};
      {sdat_q1, sdat_q2}             <= {ser_data, sdat_q1};
      {sen_q1, sen_q2}               <= {ser_en_n, sen_q1};
    end
  end
  // Serial frame state
  always_comb begin
    ser_state_next = ser_state_reg;
    case (ser_state_reg)
      ADCOF_SER_IDLE: begin
        if (!sen_q2) ser_state_next = ADCOF_SER_SHIFT;
      end
      ADCOF_SER_SHIFT: begin
        if (sen_q2) ser_state_next = ADCOF_SER_IDLE;
        else if (frame_done) ser_state_next = ADCOF_SER_DONE;
      end
      default: begin
        if (sen_q2) ser_state_next = ADCOF_SER_IDLE;
      end
    endcase
  end
  // Shift register and bit count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ser_state_reg <= ADCOF_SER_IDLE;
      shift_reg     <= '0;
      bit_cnt_reg   <= '0;
    end else begin
      ser_state_reg <= ser_state_next;
      if (ser_state_reg != ADCOF_SER_SHIFT) begin
        bit_cnt_reg <= '0;
      end else if (ser_fall) begin
        shift_reg   <= frame_word[14:0];
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
    end
  end
  // Address decode
  always_comb begin
    {sel_timing, sel_order, sel_patfmt} = 3'h0;
    {sel_userlo, sel_gain, sel_lvds}    = 3'h0;
    if (frame_addr == ADCOF_ADDR_TIMING) sel_timing = frame_done;
    else if (frame_addr == ADCOF_ADDR_ORDER) sel_order = frame_done;
    else if (frame_addr == ADCOF_ADDR_PATFMT) sel_patfmt = frame_done;
    else if (frame_addr == ADCOF_ADDR_USER_LO) sel_userlo = frame_done;
    else if (frame_addr == ADCOF_ADDR_GAIN) sel_gain = frame_done;
    else if (frame_addr == ADCOF_ADDR_LVDS) sel_lvds = frame_done;
  end
  // Register writes; fixed-zero bits are never stored
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {timing_reg, order_reg, patfmt_reg} <= {3{ADCOF_REG_RST}};
      {userlo_reg, gain_reg, lvds_reg}    <= {3{ADCOF_REG_RST}};
    end else begin
      if (sel_timing) timing_reg <= frame_data & ADCOF_MASK_TIMING;
      if (sel_order)  order_reg  <= frame_data & ADCOF_MASK_ORDER;
      if (sel_patfmt) patfmt_reg <= frame_data & ADCOF_MASK_PATFMT;
      if (sel_userlo) userlo_reg <= frame_data & ADCOF_MASK_USERLO;
      if (sel_gain)   gain_reg   <= frame_data & ADCOF_MASK_GAIN;
      if (sel_lvds)   lvds_reg   <= frame_data & ADCOF_MASK_LVDS;
    end
  end
  // Analog settings straight from the registers
  assign fine_gain     = gain_reg[ADCOF_POS_GAIN +: 3];
  assign lvds_curr     = lvds_reg[ADCOF_POS_CURR +: 2];
  assign data_curr_dbl = lvds_reg[ADCOF_POS_DATA_DBL];
  assign clk_curr_dbl  = lvds_reg[ADCOF_POS_CLK_DBL];
  assign data_term     = lvds_reg[ADCOF_POS_DATA_TERM +: 3];
  assign clk_term      = lvds_reg[ADCOF_POS_CLK_TERM +: 3];
  // Word source and coding
  adcof_pat_e  pattern;
  logic        coding_bin;
  logic [11:0] user_word;
  logic [13:0] adc_word, wr_word;
  logic        toggle_reg;
  logic [13:0] ramp_reg;
  logic        fifo_wr_ready, fifo_wr_valid, push;
  assign pattern    = adcof_pat_e'(patfmt_reg[ADCOF_POS_PATTERN +: 3]);
  assign coding_bin = patfmt_reg[ADCOF_POS_CODING];
  assign user_word  = {gain_reg[ADCOF_POS_USER_HI +: 5],
                       userlo_reg[ADCOF_POS_USER_LO +: 7]};
  assign adc_word   = coding_bin ?
                      {2'b00, ~smp_data[11], smp_data[10:0]} :
                      {{2{smp_data[11]}}, smp_data};
  assign fifo_wr_valid = (pattern == ADCOF_PAT_ADC) ? smp_valid : 1'b1;
  assign push          = fifo_wr_valid & fifo_wr_ready;
  assign smp_ready     = fifo_wr_ready;
  // Output word selection
  always_comb begin
    case (pattern)
      ADCOF_PAT_ADC:    wr_word = adc_word;
      ADCOF_PAT_ZERO:   wr_word = ADCOF_WORD_ZERO;
      ADCOF_PAT_ONES:   wr_word = ADCOF_WORD_ONES;
      ADCOF_PAT_TOGGLE: wr_word = toggle_reg ? ADCOF_WORD_TOG_B :
                                               ADCOF_WORD_TOG_A;
      ADCOF_PAT_RAMP:   wr_word = ramp_reg;
      ADCOF_PAT_USER:   wr_word = {2'b00, user_word};
      default:          wr_word = ADCOF_WORD_ZERO;
    endcase
  end
  // Toggle and ramp advance once per word sent
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      toggle_reg <= 1'b0;
      ramp_reg   <= ADCOF_RAMP_START;
    end else begin
      if (pattern != ADCOF_PAT_TOGGLE) toggle_reg <= 1'b0;
      else if (push) toggle_reg <= ~toggle_reg;
      if (pattern != ADCOF_PAT_RAMP) ramp_reg <= ADCOF_RAMP_START;
      else if (push) ramp_reg <= ramp_reg + 14'h0001;
    end
  end
  // Link domain reset, settings and hold synchronisers
  logic            lrst_q1, lrst_q2;
  adcof_link_cfg_s cfg_src, cfg_q1, cfg_q2;
  logic            hold_q1, hold_q2;
  logic            fifo_rd_valid;
  logic [13:0]     fifo_rd_data;
  logic [6:0]      rise_half, fall_half, prev_fall_reg;
  logic [6:0]      dout_rise_reg, dout_fall_reg;
  logic            dout_valid_reg, oclk_delay_reg, oclk_falling_reg;
  wire             pop = fifo_rd_valid & ~hold_q2;
  assign cfg_src.clk_delay  = timing_reg[ADCOF_POS_CLK_DELAY];
  assign cfg_src.cap_edge   = timing_reg[ADCOF_POS_CAP_EDGE];
  assign cfg_src.data_shift = timing_reg[ADCOF_POS_DATA_SHIFT];
  assign cfg_src.byte_order = order_reg[ADCOF_POS_BYTE_ORDER];
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      {lrst_q1, lrst_q2} <= 2'h3;
    end else begin
      {lrst_q1, lrst_q2} <= {1'b0, lrst_q1};
    end
  end
  adcof_fifo #(
    .W (ADCOF_WORD_W),
    .D (ADCOF_FIFO_DEPTH)
  ) u_fifo (
    .wr_clk   (clk),
    .wr_rst   (rst),
    .wr_valid (fifo_wr_valid),
    .wr_data  (wr_word),
    .wr_ready (fifo_wr_ready),
    .rd_clk   (link_clk),
    .rd_rst   (lrst_q2),
    .rd_valid (fifo_rd_valid),
    .rd_data  (fifo_rd_data),
    .rd_ready (~hold_q2)
  );
  // Half-word split for the two clock edges
  assign rise_half = cfg_q2.byte_order ? fifo_rd_data[6:0] :
                                         adcof_even(fifo_rd_data);
  assign fall_half = cfg_q2.byte_order ? fifo_rd_data[13:7] :
                                         adcof_odd(fifo_rd_data);
  // DDR output stage on the link clock
  always_ff @(posedge link_clk or posedge lrst_q2) begin
    if (lrst_q2) begin
      cfg_q1           <= ADCOF_LINK_CFG_RST;
      cfg_q2           <= ADCOF_LINK_CFG_RST;
      {hold_q1, hold_q2} <= 2'h0;
      prev_fall_reg    <= '0;
      dout_rise_reg    <= '0;
      dout_fall_reg    <= '0;
      dout_valid_reg   <= 1'b0;
      oclk_delay_reg   <= 1'b0;
      oclk_falling_reg <= 1'b0;
    end else begin
      cfg_q1           <= cfg_src;
      cfg_q2           <= cfg_q1;
      {hold_q1, hold_q2} <= {link_hold, hold_q1};
      oclk_delay_reg   <= cfg_q2.clk_delay;
      oclk_falling_reg <= cfg_q2.cap_edge;
      dout_valid_reg   <= pop;
      if (pop) begin
        prev_fall_reg <= fall_half;
        dout_rise_reg <= cfg_q2.data_shift ? prev_fall_reg :
                                             rise_half;
        dout_fall_reg <= cfg_q2.data_shift ? rise_half :
                                             fall_half;
      end
    end
  end
  assign dout_rise    = dout_rise_reg;
  assign dout_fall    = dout_fall_reg;
  assign dout_valid   = dout_valid_reg;
  assign oclk_delay   = oclk_delay_reg;
  assign oclk_falling = oclk_falling_reg;
  // Checking helpers: last word pushed and its pattern
  logic [13:0] last_word_reg;
  adcof_pat_e  last_pat_reg;
  logic        last_ok_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_word_reg <= '0;
      last_pat_reg  <= ADCOF_PAT_ADC;
      last_ok_reg   <= 1'b0;
    end else if (push) begin
      last_word_reg <= wr_word;
      last_pat_reg  <= pattern;
      last_ok_reg   <= 1'b1;
    end
  end
  wire same_pat = last_ok_reg & (last_pat_reg == pattern);
  sequence s_frame_to_timing;
    frame_done && sel_timing;
  endsequence
  timing_write_a: assert property (@(posedge clk) disable iff (rst)
    s_frame_to_timing |=> timing_reg == ($past(frame_data) & ADCOF_MASK_TIMING)
  ) else $error("timing register not updated from frame");
  zero_ones_a: assert property (@(posedge clk) disable iff (rst)
    push && (pattern == ADCOF_PAT_ONES || pattern == ADCOF_PAT_ZERO) |->
      wr_word == ((pattern == ADCOF_PAT_ONES) ? ADCOF_WORD_ONES :
                                                ADCOF_WORD_ZERO)
  ) else $error("fixed pattern word wrong");
  toggle_alt_a: assert property (@(posedge clk) disable iff (rst)
    push && pattern == ADCOF_PAT_TOGGLE && same_pat |->
      wr_word == ((last_word_reg == ADCOF_WORD_TOG_A) ? ADCOF_WORD_TOG_B :
                                                        ADCOF_WORD_TOG_A)
  ) else $error("toggle pattern did not alternate");
  ramp_step_a: assert property (@(posedge clk) disable iff (rst)
    push && pattern == ADCOF_PAT_RAMP && same_pat |->
      wr_word == last_word_reg + 14'h0001
  ) else $error("ramp did not advance by one");
  user_word_a: assert property (@(posedge clk) disable iff (rst)
    push && pattern == ADCOF_PAT_USER |->
      wr_word == {2'b00, gain_reg[4:0], userlo_reg[10:4]}
  ) else $error("user pattern word wrong");
  coding_sel_a: assert property (@(posedge clk) disable iff (rst)
    push && pattern == ADCOF_PAT_ADC |->
      wr_word[11] == (smp_data[11] ^ coding_bin)
  ) else $error("sample coding wrong");
  sequence s_pop_plain;
    pop && !cfg_q2.data_shift;
  endsequence
  bit_order_a: assert property (
    @(posedge link_clk) disable iff (lrst_q2)
    (s_pop_plain and !cfg_q2.byte_order) |=>
      dout_rise_reg == adcof_even($past(fifo_rd_data)) &&
      dout_fall_reg == adcof_odd($past(fifo_rd_data))
  ) else $error("bit-wise order wrong");
  byte_order_a: assert property (
    @(posedge link_clk) disable iff (lrst_q2)
    (s_pop_plain and cfg_q2.byte_order) |=>
      {dout_fall_reg, dout_rise_reg} == $past(fifo_rd_data)
  ) else $error("byte-wise order wrong");
  half_shift_a: assert property (
    @(posedge link_clk) disable iff (lrst_q2)
    pop && cfg_q2.data_shift |=>
      dout_rise_reg == $past(prev_fall_reg) &&
      dout_fall_reg == $past(rise_half)
  ) else $error("half cycle data shift wrong");
endmodule

// ---- verif/adcof_rx_model.sv ----
`timescale 1ns/1ps
// Capture logic on the far side of the link: keeps the last two words
module adcof_rx_model (
  input  wire logic       link_clk,
  input  wire logic       rst,
  input  wire logic       stall,
  input  wire logic [6:0] dout_rise,
  input  wire logic [6:0] dout_fall,
  input  wire logic       dout_valid,
  output logic            link_hold,
  output logic [13:0]     cur_word,
  output logic [13:0]     prev_word,
  output int              n_words
);
  // Stall request changes just after the link edge
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      link_hold <= 1'b0;
    end else begin
      link_hold <= stall;
    end
  end

  // Capture each popped word, high half as the upper bits
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      cur_word  <= 14'h0000;
      prev_word <= 14'h0000;
      n_words   <= 0;
    end else if (dout_valid) begin
      prev_word <= cur_word;
      cur_word  <= {dout_fall, dout_rise};
      n_words   <= n_words + 1;
    end
  end
endmodule

// ---- verif/adc_output_format_config_test.sv ----
`timescale 1ns/1ps
// Register writes over the serial pins, checks at the link outputs
module adc_output_format_config_test
  import adcof_pkg::*;
;
  logic clk, rst, link_clk, ser_clk, ser_data, ser_en_n, smp_valid, stall;
  logic [11:0] smp_data;
  logic smp_ready, link_hold, dout_valid, oclk_delay, oclk_falling;
  logic data_curr_dbl, clk_curr_dbl;
  logic [6:0] dout_rise, dout_fall;
  logic [2:0] fine_gain, data_term, clk_term;
  logic [1:0] lvds_curr;
  logic [13:0] cw, pw, x;
  logic [6:0] ev, od;
  int n_words, n_fail, checks_done, k;
  logic [2:0] pcode [4] = '{3'h1, 3'h2, 3'h5, 3'h1};
  logic [13:0] pword [4] = '{14'h0000, 14'h3FFF, 14'h0FD5, 14'h0000};

  adcof_top i_dut (.clk(clk), .rst(rst), .link_clk(link_clk),
    .ser_clk(ser_clk), .ser_data(ser_data), .ser_en_n(ser_en_n),
    .smp_data(smp_data), .smp_valid(smp_valid), .smp_ready(smp_ready),
    .link_hold(link_hold), .dout_rise(dout_rise), .dout_fall(dout_fall),
    .dout_valid(dout_valid), .oclk_delay(oclk_delay),
    .oclk_falling(oclk_falling), .fine_gain(fine_gain),
    .lvds_curr(lvds_curr), .data_curr_dbl(data_curr_dbl),
    .clk_curr_dbl(clk_curr_dbl), .data_term(data_term),
    .clk_term(clk_term));

  adcof_rx_model i_rx (.link_clk(link_clk), .rst(rst), .stall(stall),
    .dout_rise(dout_rise), .dout_fall(dout_fall), .dout_valid(dout_valid),
    .link_hold(link_hold), .cur_word(cw), .prev_word(pw),
    .n_words(n_words));

  // Clocks: 25 ns system, 30 ns link at an unrelated phase
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    link_clk = 1'b0;
    #4;
    forever #15 link_clk = ~link_clk;
  end

  task automatic conclude();
    if (n_fail == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One frame: address then data, MSB first, fixed bits sent as zero
  task automatic wr(input logic [4:0] a, input logic [10:0] d);
    logic [15:0] f;
    f = {a, d};
    ser_en_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      ser_clk = 1'b1;
      ser_data = f[i];
      repeat (4) @(negedge clk);
      ser_clk = 1'b0;
      repeat (4) @(negedge clk);
    end
    ser_en_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask

  // Let enough words pass to flush the buffer, bounded
  task automatic flow(input int n);
    int t0;
    t0 = n_words;
    k = 0;
    while (n_words < t0 + n && k < 3000) begin
      @(negedge clk);
      k++;
    end
    if (k == 3000) begin
      n_fail++;
      conclude();
    end
  endtask

  // Watchdog against a hang
  initial begin
    #1ms;
    n_fail++;
    conclude();
  end

  initial begin
    rst = 1'b1; ser_clk = 1'b0; ser_data = 1'b0; ser_en_n = 1'b1;
    smp_valid = 1'b0; smp_data = 12'h000; stall = 1'b0;
    n_fail = 0; checks_done = 0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk(14'({fine_gain, data_term, clk_term, lvds_curr}), 14'h0000);
    chk(14'({oclk_delay, oclk_falling, smp_ready}), 14'h0001);
    // Drive and termination fields, fixed bit sent as zero
    wr(5'h0E, 11'h3FF);
    chk(14'({data_term, clk_term, lvds_curr, clk_curr_dbl, data_curr_dbl}),
        14'h03FF);
    wr(5'h0E, 11'h1A6);
    chk(14'({data_term, clk_term, lvds_curr, clk_curr_dbl, data_curr_dbl}),
        14'h01A6);
    wr(5'h0F, 11'h0F0);
    chk(14'({data_term, clk_term, lvds_curr}), 14'h0069);
    for (int g = 0; g < 7; g++) begin
      wr(5'h0C, {g[2:0], 3'b000, 5'h1F});
      chk(14'(fine_gain), 14'(g));
    end
    // Byte-wise order, user pattern words and fixed patterns
    wr(5'h09, 11'h400);
    wr(5'h0B, 11'h550);
    for (int i = 0; i < 4; i++) begin
      wr(5'h0A, {3'b000, pcode[i], 5'h00});
      flow(30);
      chk(cw, pword[i]);
    end
    wr(5'h0A, 11'h060);
    flow(30);
    chk(cw ^ pw, 14'h3FFF);
    chk(14'(cw == 14'h2AAA || cw == 14'h1555), 14'h0001);
    wr(5'h0A, 11'h080);
    flow(30);
    chk(cw, pw + 14'h0001);
    // Stalled receiver fills the buffer until it refuses
    stall = 1'b1;
    k = 0;
    while (smp_ready !== 1'b0 && k < 200) begin
      @(negedge clk);
      k++;
    end
    chk(14'(smp_ready), 14'h0000);
    stall = 1'b0;
    flow(30);
    chk(cw, pw + 14'h0001);
    // Converter samples in both codings
    smp_data = 12'h801;
    smp_valid = 1'b1;
    wr(5'h0A, 11'h000);
    flow(30);
    chk(cw, 14'h3801);
    wr(5'h0A, 11'h400);
    flow(30);
    chk(cw, 14'h0001);
    smp_valid = 1'b0;
    // Bit-wise order on the user pattern
    wr(5'h09, 11'h000);
    wr(5'h0A, 11'h0A0);
    flow(30);
    x = 14'h0FD5;
    for (int i = 0; i < 7; i++) begin
      ev[i] = x[2*i];
      od[i] = x[2*i+1];
    end
    chk(14'(dout_rise), 14'(ev));
    chk(14'(dout_fall), 14'(od));
    // Clock delay, falling capture edge and half-cycle data shift
    wr(5'h09, 11'h400);
    wr(5'h04, 11'h700);
    flow(30);
    chk(14'({oclk_delay, oclk_falling}), 14'h0003);
    chk(14'(dout_rise), 14'(x[13:7]));
    chk(14'(dout_fall), 14'(x[6:0]));
    conclude();
  end
endmodule
